// ==== dv/core_model.sv ====
// processor core model: takes vectors and keeps a return stack
// assumes the irq_ctrl core link; returns RET_DLY cycles after the latest take, a new take restarts the count
`timescale 1ns/1ns
module core_model #(
  parameter int DEPTH = 2,
  parameter int RET_DLY = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire irq_pkg::core_out_t core_o,
  input wire logic full_cmd,
  output irq_pkg::core_in_t core,
  output logic [7:0] last_vec,
  output logic [7:0] n_taken
);
  logic take_reg;
  logic ret_reg;
  logic [3:0] depth_reg;
  logic [4:0] ret_cnt_reg;
  // full when every level is used or a scenario asks for it
  assign core = '{stack_full: full_cmd || depth_reg == 4'(DEPTH), take: take_reg,
    ret_irq_return_instr: ret_reg};
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      take_reg <= 1'b0;
      ret_reg <= 1'b0;
      depth_reg <= 4'h0;
      ret_cnt_reg <= 5'h0;
      last_vec <= 8'h00;
      n_taken <= 8'h00;
    end else begin
      take_reg <= core_o.req && !take_reg && !core.stack_full;
      ret_reg <= ret_cnt_reg == 5'h1;
      if (ret_cnt_reg == 5'h1) depth_reg <= depth_reg - 4'h1;
      if (ret_cnt_reg != 5'h0) ret_cnt_reg <= ret_cnt_reg - 5'h1;
      if (take_reg && core_o.req) begin
        last_vec <= core_o.vector;
        n_taken <= n_taken + 8'h1;
        depth_reg <= depth_reg + 4'h1;
        ret_cnt_reg <= 5'(RET_DLY);
      end
    end
  end
endmodule : core_model

// ==== dv/irq_ctrl_sva.sv ====
// port checker for the interrupt request block
// assumes bound to irq_ctrl, one core_clk domain, sync active-low reset
`timescale 1ns/1ns
module irq_ctrl_sva #(
  parameter int N_EXT = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire irq_pkg::reg_req_t bus,
  input wire logic [7:0] rdata,
  input wire logic [N_EXT-1:0] pull_high_sel,
  input wire logic [N_EXT-1:0] pull_high_on,
  input wire irq_pkg::core_in_t core,
  input wire irq_pkg::core_out_t core_o
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  stack_block_a: assert property (core.stack_full |=> !core_o.req)
    else $error("request raised while stack full");
  req_rise_a: assert property ($rose(core_o.req) |-> !$past(core.stack_full))
    else $error("request rose after a full stack");
  take_drop_a: assert property (core.take && core_o.req |=> !core_o.req)
    else $error("request stayed after take");
  global_block_a: assert property (core.take && core_o.req ##1 !core.ret_irq_return_instr && !bus.wr
    |-> ##2 !core_o.req)
    else $error("request without global enable");
  vec_range_a: assert property (core_o.req |-> core_o.vector inside
    {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c})
    else $error("vector outside table");
  rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data without read");
  unmapped_read_a: assert property (bus.rd && bus.addr > irq_pkg::ADDR_VECTOR |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  pull_copy_a: assert property ($past(rst_n) |-> pull_high_on == $past(pull_high_sel))
    else $error("pull-high lost");
  vec_read_a: assert property (bus.rd && bus.addr == irq_pkg::ADDR_VECTOR
    |=> rdata == $past(core_o.vector))
    else $error("vector read differs");
  take_c: cover property (core.take && core_o.req);
  wake_c: cover property (core_o.wake);
  full_c: cover property (core.stack_full && !core_o.req);
endmodule : irq_ctrl_sva

// ==== dv/tb.sv ====
// self-checking bench for irq_ctrl with a core model and port checker
// assumes irq_pkg, irq_ctrl, core_model and irq_ctrl_sva compiled before
`timescale 1ns/1ns
module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  irq_pkg::reg_req_t bus = '0;
  irq_pkg::src_evt_t evt = '0;
  irq_pkg::core_in_t core;
  irq_pkg::core_out_t core_o;
  logic [7:0] rdata;
  logic [7:0] last_vec;
  logic [7:0] n_taken;
  logic [1:0] pin = 2'h0;
  logic [1:0] ph_sel = 2'h1;
  logic [1:0] ph_on;
  logic [1:0] sub_cnt = 2'h0;
  logic sub_tick = 1'b0;
  logic full_cmd = 1'b0;
  logic lp;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    sub_cnt <= (sub_cnt == 2'h2) ? 2'h0 : sub_cnt + 2'h1;
    sub_tick <= (sub_cnt == 2'h2);
  end
  irq_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .ext_irq_pin(pin), .pull_high_sel(ph_sel), .pull_high_on(ph_on), .sub_clk_tick(sub_tick),
    .evt(evt), .core(core), .core_o(core_o), .slow_xtal_low_power(lp));
  core_model cpu (.core_clk(core_clk), .rst_n(rst_n), .core_o(core_o), .full_cmd(full_cmd),
    .core(core), .last_vec(last_vec), .n_taken(n_taken));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 chk({24'h0, rdata}, {24'h0, e});
  endtask : rd
  task automatic pin_to(input logic [1:0] v);
    @(posedge core_clk);
    pin <= v;
    repeat (3) @(posedge core_clk);
  endtask : pin_to
  task automatic wait_take(input logic [7:0] n);
    for (int i = 0; i < 60 && n_taken !== n; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk({24'h0, n_taken}, {24'h0, n});
  endtask : wait_take
  task automatic wait_wake(input int lim, output int t);
    t = -1;
    for (int i = 0; i < lim && t < 0; i++) begin
      #1;
      if (core_o.wake === 1'b1) t = cyc;
      @(posedge core_clk);
    end
  endtask : wait_wake
  task automatic t_regs();
    rd(irq_pkg::ADDR_TICKCTL, 8'h37);
    rd(irq_pkg::ADDR_VECTOR, 8'h04);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    wr(irq_pkg::ADDR_CTRL1, 8'h0f);
    rd(irq_pkg::ADDR_CTRL1, 8'h0f);
    wr(irq_pkg::ADDR_CTRL1, 8'h00);
    ph_sel <= 2'h2;
    chk({31'h0, lp}, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_ext();
    logic [1:0] c;
    wr(irq_pkg::ADDR_EDGE, 8'h0f);
    pin_to(2'h1);
    pin_to(2'h0);
    rd(irq_pkg::ADDR_CTRL0, 8'h00);
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      wr(irq_pkg::ADDR_EDGE, {6'h0, c});
      wr(irq_pkg::ADDR_CTRL0, 8'h02);
      pin_to(2'h1);
      rd(irq_pkg::ADDR_CTRL0, {3'h0, c[0], 4'h2});
      wr(irq_pkg::ADDR_CTRL0, 8'h02);
      pin_to(2'h0);
      rd(irq_pkg::ADDR_CTRL0, {3'h0, c[1], 4'h2});
    end
    wr(irq_pkg::ADDR_EDGE, 8'h05);
    wr(irq_pkg::ADDR_CTRL0, 8'h06);
    pin_to(2'h3);
    full_cmd <= 1'b1;
    wr(irq_pkg::ADDR_CTRL0, 8'h37);
    repeat (10) @(posedge core_clk);
    chk({24'h0, n_taken}, 32'h0);
    full_cmd <= 1'b0;
    wait_take(8'h1);
    chk({24'h0, last_vec}, 32'h4);
    rd(irq_pkg::ADDR_CTRL0, 8'h26);
    wait_take(8'h2);
    chk({24'h0, last_vec}, 32'h8);
    repeat (12) @(posedge core_clk);
    rd(irq_pkg::ADDR_CTRL0, 8'h07);
    $display("test ext done");
  endtask : t_ext
  task automatic t_group();
    logic [8:0] ev [5] = '{9'h040, 9'h004, 9'h020, 9'h002, 9'h001};
    logic [3:0] ga [5] = '{4'h3, 4'h4, 4'h4, 4'h5, 4'h5};
    logic [7:0] en [5] = '{8'h01, 8'h04, 8'h02, 8'h02, 8'h01};
    logic [7:0] me [5] = '{8'h02, 8'h04, 8'h04, 8'h08, 8'h08};
    logic [7:0] vc [5] = '{8'h14, 8'h18, 8'h18, 8'h1c, 8'h1c};
    int w;
    for (int k = 0; k < 5; k++) begin
      wr(irq_pkg::ADDR_CTRL1, me[k]);
      wr(ga[k], en[k]);
      wr(irq_pkg::ADDR_CTRL0, 8'h01);
      @(posedge core_clk);
      evt <= ev[k];
      @(posedge core_clk);
      evt <= '0;
      wait_wake(4, w);
      chk({31'h0, w >= 0}, 32'h1);
      wait_take(k[7:0] + 8'h3);
      chk({24'h0, last_vec}, {24'h0, vc[k]});
      rd(ga[k], en[k] | (en[k] << 4));
      rd(irq_pkg::ADDR_CTRL1, me[k]);
      wr(ga[k], en[k]);
      repeat (10) @(posedge core_clk);
    end
    $display("test group done");
  endtask : t_group
  task automatic t_tick();
    logic [7:0] cfg [4] = '{8'hc8, 8'hc1, 8'h80, 8'hc7};
    int per [4] = '{1024, 2048, 768, 16384};
    int t0;
    int t1;
    for (int k = 0; k < 4; k++) begin
      wr(irq_pkg::ADDR_TICKCTL, cfg[k]);
      wr(irq_pkg::ADDR_CTRL0, 8'h00);
      wr(irq_pkg::ADDR_CTRL1, 8'h00);
      wait_wake(2 * per[k] + 50, t0);
      wr(irq_pkg::ADDR_CTRL0, 8'h00);
      wr(irq_pkg::ADDR_CTRL1, 8'h00);
      wait_wake(per[k] + 50, t1);
      chk(t1 - t0, per[k]);
      chk({31'h0, lp}, {31'h0, cfg[k][3]});
    end
    wr(irq_pkg::ADDR_TICKCTL, 8'h40);
    wait_wake(3000, t0);
    chk(t0, -1);
    $display("test tick done");
  endtask : t_tick
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_ext();
    t_group();
    t_tick();
    finish_test();
  end
  initial begin
    repeat (80000) @(posedge core_clk);
    failures++;
    finish_test();
  end
endmodule : tb
bind irq_ctrl irq_ctrl_sva #(.N_EXT(N_EXT)) sva (.core_clk(core_clk), .rst_n(rst_n), .bus(bus),
  .rdata(rdata), .pull_high_sel(pull_high_sel), .pull_high_on(pull_high_on), .core(core),
  .core_o(core_o));

// ==== logic/irq_ctrl.sv ====
// interrupt request logic: pin edges, two time bases, three shared groups
// assumes pins and events are synchronous to core_clk; core takes one vector per take pulse
// Notes on behaviour
// R1 - pin flag sets on the edge type chosen for that pin
// R2 - pin vectors only with global and pin enable, stack not full
// R3 - servicing a pin clears its flag and the global enable
// R4 - edge select picks rising, falling, both, or off
// R5 - pin acts as interrupt input only while its enable is set
// R6 - pull-high on the pin stays on while used as interrupt
// R7 - group flag sets when any member source flag sets; code sets it only on an event of a member whose own enable is set
// R8 - servicing a group clears group flag and global enable
// R9 - software clears source flags inside groups itself
// R10 - each time base sets its flag on divider overflow
// R11 - time base vectors with global and own enable; service clears both
// R12 - clock select bit: sub clock when 0, system clock over four when 1
// R13 - one on bit runs or stops both time base counters
// R14 - second time base period two to the 12 through 15
// R15 - first time base period two to the 8 through 15
// R16 - low power bit picks quick or low-power crystal start
// R17 - eeprom flag sets when a write finishes, member of a group
// R18 - eeprom vectors with global, own and group enable, stack free
// R19 - low supply flag sets on detector report; vectors when all enabled
// R20 - timers give period and a-match flags; enhanced timer adds b-match
// R21 - timer match vectors with all enables; service clears group only
// R22 - taking pushes counter and loads vector; return re-sets global enable
// R23 - any flag rising raises wake-up regardless of enables
// R24 - simultaneous requests served lowest vector first
// R25 - flag set while global enable off stays pending
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module irq_ctrl #(
  parameter int N_EXT = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire irq_pkg::reg_req_t bus,
  output logic [7:0] rdata,
  input wire logic [N_EXT-1:0] ext_irq_pin,
  input wire logic [N_EXT-1:0] pull_high_sel,
  output logic [N_EXT-1:0] pull_high_on,
  input wire logic sub_clk_tick,
  input wire irq_pkg::src_evt_t evt,
  input wire irq_pkg::core_in_t core,
  output irq_pkg::core_out_t core_o,
  output logic slow_xtal_low_power
);
  // elaboration check: the register map carries exactly two pins
  if (N_EXT != 2) begin : g_bad_ext
    $error("two external pins supported");
  end

  typedef struct packed {
    logic global_irq_en;
    logic [1:0] ext_irq_en;
    logic [1:0] ext_irq_flag;
    logic [1:0] tick_irq_en;
    logic [1:0] tick_irq_flag;
    logic [2:0] group_irq_en;
    logic [2:0] group_irq_flag;
    logic [3:0] edge_select_reg;
    logic [2:0] timer_period_match_flag;
    logic [2:0] timer_a_match_flag;
    logic timer_b_match_flag;
    logic [2:0] timer_period_match_en;
    logic [2:0] timer_a_match_en;
    logic timer_b_match_en;
    logic eeprom_done_flag;
    logic eeprom_done_en;
    logic low_supply_flag;
    logic low_supply_en;
    logic [7:0] tick_ctl;
    logic [1:0] pre_cnt;
    logic [14:0] tick_cnt;
    logic [1:0] pin_last;
    logic [7:0] rdata;
    logic [1:0] pull;
    logic req;
    logic [7:0] vector;
    logic wake;
    logic [2:0] last_src;
  } state_t;

  state_t st_reg, st_next;

  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    unique case (sel)
      irq_pkg::EDGE_OFF: edge_hit = 1'b0;
      irq_pkg::EDGE_RISE: edge_hit = !prev && cur;
      irq_pkg::EDGE_FALL: edge_hit = prev && !cur;
      irq_pkg::EDGE_BOTH: edge_hit = prev != cur;
    endcase
  endfunction : edge_hit

  // all-ones mask of the low 'exp' bits of the tick counter
  function automatic logic period_done(input logic [14:0] cnt, input int exp);
    logic [14:0] mask;
    mask = 15'(({15'h0, 1'b1} << exp) - 1);
    period_done = (cnt & mask) == mask;
  endfunction : period_done

  logic [irq_pkg::NSRC-1:0] pend;
  logic [irq_pkg::NSRC-1:0] flags_now;
  logic [2:0] win;
  logic tick_en;
  logic ev0, ev1;
  logic [31:0] flat_before, flat_after;

  always_comb begin
    st_next = st_reg;
    st_next.wake = 1'b0;
    st_next.pin_last = ext_irq_pin;
    st_next.pull = pull_high_sel; // see R6
    // software writes first so hardware sets win over clears
    if (bus.wr) begin
      unique case (bus.addr)
        irq_pkg::ADDR_CTRL0: begin
          st_next.global_irq_en = bus.wdata[0];
          st_next.ext_irq_en = bus.wdata[2:1];
          st_next.tick_irq_en[0] = bus.wdata[3];
          st_next.ext_irq_flag = bus.wdata[5:4];
          st_next.tick_irq_flag[0] = bus.wdata[6];
        end
        irq_pkg::ADDR_CTRL1: begin
          st_next.tick_irq_en[1] = bus.wdata[0];
          st_next.group_irq_en = bus.wdata[3:1];
          st_next.tick_irq_flag[1] = bus.wdata[4];
          st_next.group_irq_flag = bus.wdata[7:5];
        end
        irq_pkg::ADDR_EDGE: st_next.edge_select_reg = bus.wdata[3:0];
        irq_pkg::ADDR_GRP0: begin
          st_next.timer_period_match_en[1:0] = bus.wdata[1:0];
          st_next.timer_a_match_en[1:0] = bus.wdata[3:2];
          st_next.timer_period_match_flag[1:0] = bus.wdata[5:4];
          st_next.timer_a_match_flag[1:0] = bus.wdata[7:6];
        end
        irq_pkg::ADDR_GRP1: begin
          st_next.timer_period_match_en[2] = bus.wdata[0];
          st_next.timer_a_match_en[2] = bus.wdata[1];
          st_next.timer_b_match_en = bus.wdata[2];
          st_next.timer_period_match_flag[2] = bus.wdata[4];
          st_next.timer_a_match_flag[2] = bus.wdata[5];
          st_next.timer_b_match_flag = bus.wdata[6];
        end
        irq_pkg::ADDR_GRP2: begin
          st_next.low_supply_en = bus.wdata[0];
          st_next.eeprom_done_en = bus.wdata[1];
          st_next.low_supply_flag = bus.wdata[4];
          st_next.eeprom_done_flag = bus.wdata[5];
        end
        irq_pkg::ADDR_TICKCTL: st_next.tick_ctl = bus.wdata;
        default: ;
      endcase
    end
    // service: clear only direct or group flag and global enable
    // placed before hardware sets so a new event in the take cycle survives
    if (core.take && st_reg.req) begin
      st_next.global_irq_en = 1'b0; // see R3, R8, R11
      unique case (st_reg.last_src)
        3'(irq_pkg::SRC_EXT0): st_next.ext_irq_flag[0] = 1'b0; // see R3
        3'(irq_pkg::SRC_EXT1): st_next.ext_irq_flag[1] = 1'b0; // see R3
        3'(irq_pkg::SRC_TB0): st_next.tick_irq_flag[0] = 1'b0; // see R11
        3'(irq_pkg::SRC_TB1): st_next.tick_irq_flag[1] = 1'b0; // see R11
        3'(irq_pkg::SRC_MF0): st_next.group_irq_flag[0] = 1'b0; // see R8, R9
        3'(irq_pkg::SRC_MF1): st_next.group_irq_flag[1] = 1'b0; // see R8, R9
        3'(irq_pkg::SRC_MF2): st_next.group_irq_flag[2] = 1'b0; // see R8, R9
        default: ;
      endcase
    end
    // pin edges, only while pin enabled
    for (int i = 0; i < 2; i++) begin
      if (st_reg.ext_irq_en[i] && // see R5
          edge_hit(st_reg.edge_select_reg[2*i +: 2], st_reg.pin_last[i], ext_irq_pin[i]))
        st_next.ext_irq_flag[i] = 1'b1; // see R1, R4
    end
    // time base: prescale, clock select, overflow
    tick_en = 1'b0;
    if (st_reg.tick_ctl[irq_pkg::TB_CLKSEL]) begin // see R12
      st_next.pre_cnt = st_reg.pre_cnt + 2'h1;
      tick_en = st_reg.pre_cnt == irq_pkg::PRE_LAST;
    end else begin
      tick_en = sub_clk_tick;
    end
    ev0 = 1'b0;
    ev1 = 1'b0;
    if (!st_reg.tick_ctl[irq_pkg::TB_ON]) begin // see R13
      st_next.tick_cnt = '0;
      st_next.pre_cnt = '0;
    end else if (tick_en) begin
      st_next.tick_cnt = st_reg.tick_cnt + 15'h1;
      ev0 = period_done(st_reg.tick_cnt, irq_pkg::TB0_EXP_BASE +
        int'(st_reg.tick_ctl[irq_pkg::TB0_HI:irq_pkg::TB0_LO])); // see R15
      ev1 = period_done(st_reg.tick_cnt, irq_pkg::TB1_EXP_BASE +
        int'(st_reg.tick_ctl[irq_pkg::TB1_HI:irq_pkg::TB1_LO])); // see R14
    end
    if (ev0) st_next.tick_irq_flag[0] = 1'b1; // see R10
    if (ev1) st_next.tick_irq_flag[1] = 1'b1; // see R10
    // group sources
    st_next.timer_period_match_flag = st_next.timer_period_match_flag | evt.tm_p; // see R20
    st_next.timer_a_match_flag = st_next.timer_a_match_flag | evt.tm_a; // see R20
    if (evt.tm_b) st_next.timer_b_match_flag = 1'b1; // see R20
    if (evt.eeprom_done) st_next.eeprom_done_flag = 1'b1; // see R17
    if (evt.low_supply) st_next.low_supply_flag = 1'b1; // see R19
    // group flag sets on an event of a member whose own enable is set
    if (|(evt.tm_p[1:0] & st_reg.timer_period_match_en[1:0]) ||
        |(evt.tm_a[1:0] & st_reg.timer_a_match_en[1:0]))
      st_next.group_irq_flag[0] = 1'b1; // see R7, R21
    if ((evt.tm_p[2] && st_reg.timer_period_match_en[2]) ||
        (evt.tm_a[2] && st_reg.timer_a_match_en[2]) ||
        (evt.tm_b && st_reg.timer_b_match_en))
      st_next.group_irq_flag[1] = 1'b1; // see R7, R21
    if ((evt.eeprom_done && st_reg.eeprom_done_en) ||
        (evt.low_supply && st_reg.low_supply_en))
      st_next.group_irq_flag[2] = 1'b1; // see R7, R18, R19
    // pending requests; flags stay until serviced
    flags_now = {st_reg.group_irq_flag, st_reg.tick_irq_flag, st_reg.ext_irq_flag};
    pend = flags_now & {st_reg.group_irq_en, st_reg.tick_irq_en, st_reg.ext_irq_en}; // see R25
    win = irq_pkg::VEC_NONE;
    for (int i = irq_pkg::NSRC - 1; i >= 0; i--) begin
      if (pend[i]) win = 3'(i); // see R24
    end
    st_next.req = st_reg.global_irq_en && !core.stack_full && win != irq_pkg::VEC_NONE &&
      !(core.take && st_reg.req); // see R2, R11, R18
    if (win != irq_pkg::VEC_NONE) begin
      st_next.vector = irq_pkg::VEC_BASE + 8'(irq_pkg::VEC_STEP * win); // see R22
      st_next.last_src = win;
    end
    if (core.ret_irq_return_instr) st_next.global_irq_en = 1'b1; // see R22
    // wake on any flag rising
    flat_before = {st_reg.ext_irq_flag, st_reg.tick_irq_flag, st_reg.group_irq_flag,
      st_reg.timer_period_match_flag, st_reg.timer_a_match_flag, st_reg.timer_b_match_flag,
      st_reg.eeprom_done_flag, st_reg.low_supply_flag, 16'h0};
    flat_after = {st_next.ext_irq_flag, st_next.tick_irq_flag, st_next.group_irq_flag,
      st_next.timer_period_match_flag, st_next.timer_a_match_flag, st_next.timer_b_match_flag,
      st_next.eeprom_done_flag, st_next.low_supply_flag, 16'h0};
    st_next.wake = |(flat_after & ~flat_before); // see R23
    // read data, one cycle later
    st_next.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        irq_pkg::ADDR_CTRL0: st_next.rdata = {1'b0, st_reg.tick_irq_flag[0], st_reg.ext_irq_flag,
          st_reg.tick_irq_en[0], st_reg.ext_irq_en, st_reg.global_irq_en};
        irq_pkg::ADDR_CTRL1: st_next.rdata = {st_reg.group_irq_flag, st_reg.tick_irq_flag[1],
          st_reg.group_irq_en, st_reg.tick_irq_en[1]};
        irq_pkg::ADDR_EDGE: st_next.rdata = {4'h0, st_reg.edge_select_reg};
        irq_pkg::ADDR_GRP0: st_next.rdata = {st_reg.timer_a_match_flag[1:0],
          st_reg.timer_period_match_flag[1:0], st_reg.timer_a_match_en[1:0],
          st_reg.timer_period_match_en[1:0]};
        irq_pkg::ADDR_GRP1: st_next.rdata = {1'b0, st_reg.timer_b_match_flag,
          st_reg.timer_a_match_flag[2], st_reg.timer_period_match_flag[2], 1'b0,
          st_reg.timer_b_match_en, st_reg.timer_a_match_en[2], st_reg.timer_period_match_en[2]};
        irq_pkg::ADDR_GRP2: st_next.rdata = {2'h0, st_reg.eeprom_done_flag,
          st_reg.low_supply_flag, 2'h0, st_reg.eeprom_done_en, st_reg.low_supply_en};
        irq_pkg::ADDR_TICKCTL: st_next.rdata = st_reg.tick_ctl;
        irq_pkg::ADDR_VECTOR: st_next.rdata = st_reg.vector;
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.tick_ctl <= irq_pkg::TICKCTL_RESET;
      st_reg.vector <= irq_pkg::VEC_BASE;
      st_reg.last_src <= irq_pkg::VEC_NONE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign pull_high_on = st_reg.pull; // see R6
  assign core_o = '{req: st_reg.req, vector: st_reg.vector, wake: st_reg.wake};
  assign slow_xtal_low_power = st_reg.tick_ctl[irq_pkg::TB_SLOW_XTAL_LOW_POWER]; // see R16
endmodule : irq_ctrl

// ==== logic/irq_pkg.sv ====
// package for the interrupt sources and time base block
// assumes a single 100 MHz core clock and a plain register port
package irq_pkg;
  localparam int CLK_MHZ = 100;
  localparam int TICK_PRESCALE = 4;
  localparam logic [1:0] PRE_LAST = 2'h3;
  // register addresses (4-bit word index)
  localparam logic [3:0] ADDR_CTRL0 = 4'h0;
  localparam logic [3:0] ADDR_CTRL1 = 4'h1;
  localparam logic [3:0] ADDR_EDGE = 4'h2;
  localparam logic [3:0] ADDR_GRP0 = 4'h3;
  localparam logic [3:0] ADDR_GRP1 = 4'h4;
  localparam logic [3:0] ADDR_GRP2 = 4'h5;
  localparam logic [3:0] ADDR_TICKCTL = 4'h6;
  localparam logic [3:0] ADDR_VECTOR = 4'h7;
  localparam logic [7:0] TICKCTL_RESET = 8'h37;
  // time base control fields
  localparam int TB_ON = 7;
  localparam int TB_CLKSEL = 6;
  localparam int TB1_HI = 5;
  localparam int TB1_LO = 4;
  localparam int TB_SLOW_XTAL_LOW_POWER = 3;
  localparam int TB0_HI = 2;
  localparam int TB0_LO = 0;
  localparam int TB0_EXP_BASE = 8;
  localparam int TB1_EXP_BASE = 12;
  localparam int TB_CNT_W = 15;
  // edge select codes per pin
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // request indices, also priority order (lowest wins)
  localparam int SRC_EXT0 = 0;
  localparam int SRC_EXT1 = 1;
  localparam int SRC_TB0 = 2;
  localparam int SRC_TB1 = 3;
  localparam int SRC_MF0 = 4;
  localparam int SRC_MF1 = 5;
  localparam int SRC_MF2 = 6;
  localparam int NSRC = 7;
  localparam logic [7:0] VEC_BASE = 8'h04;
  localparam logic [7:0] VEC_STEP = 8'h04;
  localparam logic [2:0] VEC_NONE = 3'h7;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [2:0] tm_p;
    logic [2:0] tm_a;
    logic tm_b;
    logic eeprom_done;
    logic low_supply;
  } src_evt_t;

  typedef struct packed {
    logic stack_full;
    logic take;
    logic ret_irq_return_instr;
  } core_in_t;

  typedef struct packed {
    logic req;
    logic [7:0] vector;
    logic wake;
  } core_out_t;
endpackage : irq_pkg
